/* rtl/rtc_trip_logic.sv */
// Coincidence voting, permissive interlocks and trip outputs for both logic trains
//
// Operation
// - Trip when two of four power range channels exceed high flux setpoint.
// - Each power range channel has high and low settings; high never bypassed.
// - Low power range bypass accepted only with two of four above P-10.
// - Three of four below P-10 cancels low setting bypass.
// - Either intermediate range channel over setpoint trips unless blocked.
// - Intermediate range block accepted only with two of four above P-10.
// - Three of four below P-10 removes intermediate range block.
// - Intermediate range channels bypass individually for test, with annunciation.
// - Either source range channel over setpoint trips unless bypassed.
// - Source range bypass accepted only with an intermediate channel above P-6.
// - Both intermediate channels below P-6 cancel the source range bypass.
// - Below P-10 each reinstate switch restores source trip in one train.
// - Source range channels bypass individually for test, with annunciation.
// - Two of four power range rate channels trip; never bypassable.
// - Turbine trip asserted whenever a reactor trip is initiated.
// - Manual trip switch trips regardless of automatic votes.
// - Any satisfied trip vote not bypassed or blocked drives the trip breaker outputs; the P-10 votes do not.
// - Overtemperature vote uses one bistable per loop from its own temperatures.
// - Each loop takes one pressurizer pressure from the four instruments.
// - Overtemperature setpoint falls with flux difference beyond a deadband.
// - Each overtemperature channel uses its own dedicated flux input.
// - Each train drives its own breaker; either one suffices to trip.
`timescale 1ns/1ps
module rtc_trip_logic (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] pr_high_bist,
  input wire logic [3:0] pr_low_bist,
  input wire logic [3:0] pr_rate_bist,
  input wire logic [3:0] pr_p10_bist,
  input wire logic [1:0] ir_high_bist,
  input wire logic [1:0] ir_p6_bist,
  input wire logic [1:0] sr_high_bist,
  input wire logic manual_trip_sw,
  input wire logic [1:0] sr_reinstate_sw,
  input wire logic [31:0] ot_delta_t,
  input wire logic [31:0] ot_flux_diff,
  input wire logic [31:0] pzr_press,
  output logic train_a_trip_breaker,
  output logic train_b_trip_breaker,
  output logic turbine_trip,
  output logic ir_test_annunc,
  output logic sr_test_annunc
);
  localparam int SW = 25;

  rtc_pkg::rtc_bus_state_t bus_state;
  logic [SW-1:0] pin_q;
  logic [3:0] pr_high;
  logic [3:0] pr_low;
  logic [3:0] pr_rate;
  logic [3:0] pr_p10;
  logic [1:0] ir_high;
  logic [1:0] ir_p6;
  logic [1:0] sr_high;
  logic manual_trip;
  logic [1:0] sr_reinstate;
  logic [rtc_pkg::TB_WIDTH-1:0] test_byp;
  logic [3:0] vote_in [rtc_pkg::VOTE_COUNT];
  logic [rtc_pkg::VOTE_COUNT-1:0] vote;
  logic [rtc_pkg::NUM_LOOPS-1:0] ot_loop_trip;
  logic [rtc_pkg::NUM_TRAINS-1:0] pr_low_byp;
  logic [rtc_pkg::NUM_TRAINS-1:0] ir_blk;
  logic [rtc_pkg::NUM_TRAINS-1:0] sr_byp;
  logic [rtc_pkg::NUM_TRAINS-1:0] next_trip;
  logic [rtc_pkg::CAUSE_COUNT-1:0] cause;
  logic ir_trip;
  logic sr_trip;
  logic p6_set;
  logic p6_clr;
  logic wr_ok;
  logic req_pr_low_byp;
  logic req_ir_block;
  logic req_sr_byp;
  logic [31:0] status_word;

  // Register address match, used by both read and write decode
  function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] reg_off);
    return addr == reg_off;
  endfunction

  // All bistable and switch pins cross into the clock domain here
  rtc_pin_sync #(
    .WIDTH(SW)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .pin({sr_reinstate_sw, manual_trip_sw, sr_high_bist, ir_p6_bist, ir_high_bist,
          pr_p10_bist, pr_rate_bist, pr_low_bist, pr_high_bist}),
    .q(pin_q)
  );

  // Unpack synchronised pins
  assign pr_high = pin_q[3:0];
  assign pr_low = pin_q[7:4];
  assign pr_rate = pin_q[11:8];
  assign pr_p10 = pin_q[15:12];
  assign ir_high = pin_q[17:16];
  assign ir_p6 = pin_q[19:18];
  assign sr_high = pin_q[21:20];
  assign manual_trip = pin_q[22];
  assign sr_reinstate = pin_q[24:23];

  // Four-channel vote inputs; high setting has its own comparison from the low one
  assign vote_in[rtc_pkg::VOTE_PR_HIGH] = pr_high;
  assign vote_in[rtc_pkg::VOTE_PR_LOW] = pr_low;
  assign vote_in[rtc_pkg::VOTE_RATE] = pr_rate;
  assign vote_in[rtc_pkg::VOTE_P10_SET] = pr_p10;
  assign vote_in[rtc_pkg::VOTE_P10_CLR] = ~pr_p10;
  assign vote_in[rtc_pkg::VOTE_OT] = ot_loop_trip;

  // One voter per coincidence function
  for (genvar v = 0; v < rtc_pkg::VOTE_COUNT; v++) begin : g_vote
    rtc_vote #(
      .N(rtc_pkg::NUM_PR),
      .K(rtc_pkg::VOTE_K[v])
    ) u_vote (
      .bits(vote_in[v]),
      .met(vote[v])
    );
  end

  // One-of-two votes; a channel under test bypass drops out of its trip vote but still counts for P-6
  assign ir_trip = |(ir_high & ~test_byp[rtc_pkg::TB_IR_LSB +: 2]);
  assign sr_trip = |(sr_high & ~test_byp[rtc_pkg::TB_SR_LSB +: 2]);
  assign p6_set = |ir_p6;
  assign p6_clr = ~|ir_p6;

  // Overtemperature setpoint per loop from that loop's own signals
  for (genvar l = 0; l < rtc_pkg::NUM_LOOPS; l++) begin : g_loop
    logic [7:0] flux;
    logic [8:0] abs_di;
    logic [8:0] excess;
    logic signed [10:0] press_term;
    logic signed [10:0] setpoint;

    // Own flux detector and own pressure instrument for this loop
    always_comb begin
      flux = ot_flux_diff[8*l +: 8];
      abs_di = flux[7] ? 9'(~{flux[7], flux} + 9'h001) : {1'b0, flux};
      excess = (abs_di > {1'b0, rtc_pkg::OT_DEADBAND}) ?
               9'(abs_di - {1'b0, rtc_pkg::OT_DEADBAND}) : 9'h000;
      press_term = 11'($signed({3'b000, pzr_press[8*l +: 8]}) -
                       $signed({3'b000, rtc_pkg::OT_PRESS_NOM})) >>> rtc_pkg::OT_PRESS_SHIFT;
      setpoint = 11'($signed({3'b000, rtc_pkg::OT_BASE}) + press_term -
                     $signed({2'b00, excess}));
    end

    // Per-loop trip bistable
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ot_loop_trip[l] <= 1'b0;
      end else if (ce) begin
        ot_loop_trip[l] <= $signed({3'b000, ot_delta_t[8*l +: 8]}) > setpoint;
      end
    end

    a_ot_deadband: assert property (@(posedge sys_clk) disable iff (!resetn)
      (abs_di <= {1'b0, rtc_pkg::OT_DEADBAND}) |->
      setpoint == 11'($signed({3'b000, rtc_pkg::OT_BASE}) + press_term))
      else $error("setpoint moved inside flux deadband");
  end

  // Bus handshake: one wait cycle, then waitrequest low for exactly one edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= rtc_pkg::RTC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      case (bus_state)
        rtc_pkg::RTC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= rtc_pkg::RTC_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        rtc_pkg::RTC_BUS_ACK: begin
          bus_state <= rtc_pkg::RTC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= rtc_pkg::RTC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Write takes effect at the edge that completes the handshake
  assign wr_ok = ce && avs_write && !avs_waitrequest && avs_byteenable[0];
  assign req_pr_low_byp = wr_ok && addr_is(avs_address, rtc_pkg::REG_CTRL) &&
                          avs_writedata[rtc_pkg::CTRL_PR_LOW_BYP];
  assign req_ir_block = wr_ok && addr_is(avs_address, rtc_pkg::REG_CTRL) &&
                        avs_writedata[rtc_pkg::CTRL_IR_BLOCK];
  assign req_sr_byp = wr_ok && addr_is(avs_address, rtc_pkg::REG_CTRL) &&
                      avs_writedata[rtc_pkg::CTRL_SR_BYP];

  // Channel test bypass register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      test_byp <= rtc_pkg::TEST_BYP_RESET;
    end else if (wr_ok && addr_is(avs_address, rtc_pkg::REG_TEST_BYP)) begin
      test_byp <= avs_writedata[rtc_pkg::TB_WIDTH-1:0];
    end
  end

  // Status word assembled from live block state
  assign cause = {manual_trip, vote[rtc_pkg::VOTE_OT], vote[rtc_pkg::VOTE_RATE], sr_trip,
                  ir_trip, vote[rtc_pkg::VOTE_PR_LOW], vote[rtc_pkg::VOTE_PR_HIGH]};
  always_comb begin
    status_word = '0;
    status_word[rtc_pkg::ST_TRIP_LSB +: 2] = {train_b_trip_breaker, train_a_trip_breaker};
    status_word[rtc_pkg::ST_PR_LOW_BYP_LSB +: 2] = pr_low_byp;
    status_word[rtc_pkg::ST_IR_BLK_LSB +: 2] = ir_blk;
    status_word[rtc_pkg::ST_SR_BYP_LSB +: 2] = sr_byp;
    status_word[rtc_pkg::ST_P10] = vote[rtc_pkg::VOTE_P10_SET];
    status_word[rtc_pkg::ST_P6] = p6_set;
    status_word[rtc_pkg::ST_CAUSE_LSB +: rtc_pkg::CAUSE_COUNT] = cause;
  end

  // Read data loaded on the edge that drops waitrequest; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && bus_state == rtc_pkg::RTC_BUS_IDLE) begin
      if (addr_is(avs_address, rtc_pkg::REG_TEST_BYP)) begin
        avs_readdata <= {28'h000_0000, test_byp};
      end else if (addr_is(avs_address, rtc_pkg::REG_STATUS)) begin
        avs_readdata <= status_word;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Per-train interlock latches and trip sum
  for (genvar t = 0; t < rtc_pkg::NUM_TRAINS; t++) begin : g_train
    // Low power range setting bypass; automatic reinstatement has priority
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        pr_low_byp[t] <= 1'b0;
      end else if (ce) begin
        if (vote[rtc_pkg::VOTE_P10_CLR]) begin
          pr_low_byp[t] <= 1'b0;
        end else if (req_pr_low_byp && vote[rtc_pkg::VOTE_P10_SET]) begin
          pr_low_byp[t] <= 1'b1;
        end
      end
    end

    // Intermediate range block
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ir_blk[t] <= 1'b0;
      end else if (ce) begin
        if (vote[rtc_pkg::VOTE_P10_CLR]) begin
          ir_blk[t] <= 1'b0;
        end else if (req_ir_block && vote[rtc_pkg::VOTE_P10_SET]) begin
          ir_blk[t] <= 1'b1;
        end
      end
    end

    // Source range bypass; each reinstate switch acts on its own train only
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        sr_byp[t] <= 1'b0;
      end else if (ce) begin
        if (p6_clr) begin
          sr_byp[t] <= 1'b0;
        end else if (sr_reinstate[t] && !vote[rtc_pkg::VOTE_P10_SET]) begin
          sr_byp[t] <= 1'b0;
        end else if (req_sr_byp && p6_set) begin
          sr_byp[t] <= 1'b1;
        end
      end
    end

    // Any satisfied trip vote not bypassed or blocked, or the manual switch, trips this train
    assign next_trip[t] = vote[rtc_pkg::VOTE_PR_HIGH] ||
                          (vote[rtc_pkg::VOTE_PR_LOW] && !pr_low_byp[t]) ||
                          (ir_trip && !ir_blk[t]) ||
                          (sr_trip && !sr_byp[t]) ||
                          vote[rtc_pkg::VOTE_RATE] ||
                          vote[rtc_pkg::VOTE_OT] ||
                          manual_trip;
  end

  // Independent breaker output per train, turbine trip from either
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      train_a_trip_breaker <= 1'b0;
      train_b_trip_breaker <= 1'b0;
      turbine_trip <= 1'b0;
    end else if (ce) begin
      train_a_trip_breaker <= next_trip[0];
      train_b_trip_breaker <= next_trip[1];
      turbine_trip <= |next_trip;
    end
  end

  // Control board annunciation of channel test bypasses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ir_test_annunc <= 1'b0;
      sr_test_annunc <= 1'b0;
    end else if (ce) begin
      ir_test_annunc <= |test_byp[rtc_pkg::TB_IR_LSB +: 2];
      sr_test_annunc <= |test_byp[rtc_pkg::TB_SR_LSB +: 2];
    end
  end

  a_pr_high_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && vote[rtc_pkg::VOTE_PR_HIGH] |=> train_a_trip_breaker && train_b_trip_breaker)
    else $error("high flux coincidence did not trip both trains");

  a_pr_low_perm: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pr_low_byp[0]) |-> $past(vote[rtc_pkg::VOTE_P10_SET]))
    else $error("low setting bypassed without P-10");

  a_p10_reinstate: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && vote[rtc_pkg::VOTE_P10_CLR] |=> pr_low_byp == 2'b00 && ir_blk == 2'b00)
    else $error("bypass or block kept below P-10");

  a_ir_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && ir_trip && !ir_blk[1] |=> train_b_trip_breaker)
    else $error("intermediate range trip missed");

  a_ir_block_perm: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(ir_blk[1]) |-> $past(vote[rtc_pkg::VOTE_P10_SET]) && $past(req_ir_block))
    else $error("intermediate block without permissive");

  a_ir_annunc: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && test_byp[rtc_pkg::TB_IR_LSB] |=> ir_test_annunc)
    else $error("intermediate test bypass not annunciated");

  a_sr_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && sr_trip && !sr_byp[0] |=> train_a_trip_breaker)
    else $error("source range trip missed");

  a_sr_byp_perm: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sr_byp[0]) |-> $past(p6_set))
    else $error("source bypass without P-6");

  a_sr_cancel: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && p6_clr |=> sr_byp == 2'b00)
    else $error("source bypass kept below P-6");

  a_sr_reinstate: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && sr_reinstate == 2'b10 && !vote[rtc_pkg::VOTE_P10_SET] && sr_byp[0] && !p6_clr
    |=> !sr_byp[1] && sr_byp[0])
    else $error("reinstate switch crossed trains");

  a_rate_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && vote[rtc_pkg::VOTE_RATE] |=> train_a_trip_breaker && train_b_trip_breaker)
    else $error("rate trip missed");

  a_turbine_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    turbine_trip == (train_a_trip_breaker || train_b_trip_breaker))
    else $error("turbine trip disagrees with breakers");

  a_manual_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && manual_trip |=> train_a_trip_breaker && train_b_trip_breaker)
    else $error("manual trip ignored");

  a_byp_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && ir_blk[0] && !vote[rtc_pkg::VOTE_P10_CLR] |=> ir_blk[0])
    else $error("block dropped without reinstatement");
endmodule

/* rtl/rtc_pkg.sv */
// Shared constants and types for the reactor trip coincidence logic
package rtc_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TEST_BYP = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Control register bits (write one to request)
  localparam int CTRL_PR_LOW_BYP = 0;
  localparam int CTRL_IR_BLOCK = 1;
  localparam int CTRL_SR_BYP = 2;
  // Test bypass register layout and reset value
  localparam int TB_WIDTH = 4;
  localparam int TB_IR_LSB = 0;
  localparam int TB_SR_LSB = 2;
  localparam logic [3:0] TEST_BYP_RESET = 4'h0;
  // Status register layout
  localparam int ST_TRIP_LSB = 0;
  localparam int ST_PR_LOW_BYP_LSB = 2;
  localparam int ST_IR_BLK_LSB = 4;
  localparam int ST_SR_BYP_LSB = 6;
  localparam int ST_P10 = 8;
  localparam int ST_P6 = 9;
  localparam int ST_CAUSE_LSB = 10;
  localparam int CAUSE_COUNT = 7;
  // Channel counts
  localparam int NUM_PR = 4;
  localparam int NUM_NR = 2;
  localparam int NUM_TRAINS = 2;
  localparam int NUM_LOOPS = 4;
  // Four-channel votes: index and coincidence count
  localparam int VOTE_PR_HIGH = 0;
  localparam int VOTE_PR_LOW = 1;
  localparam int VOTE_RATE = 2;
  localparam int VOTE_P10_SET = 3;
  localparam int VOTE_P10_CLR = 4;
  localparam int VOTE_OT = 5;
  localparam int VOTE_COUNT = 6;
  localparam int VOTE_K [VOTE_COUNT] = '{2, 2, 2, 2, 3, 2};
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  // Overtemperature setpoint terms
  localparam logic [7:0] OT_BASE = 8'hA0;
  localparam logic [7:0] OT_DEADBAND = 8'h10;
  localparam logic [7:0] OT_PRESS_NOM = 8'h80;
  localparam int OT_PRESS_SHIFT = 2;
  // Register bus handshake states
  typedef enum logic {RTC_BUS_IDLE, RTC_BUS_ACK} rtc_bus_state_t;
endpackage

/* rtl/rtc_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rtc_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept each bit only when the last two stages agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule

/* rtl/rtc_vote.sv */
// K-out-of-N coincidence vote over bistable outputs
`timescale 1ns/1ps
module rtc_vote #(
  parameter int N = 4,
  parameter int K = 2
) (
  input wire logic [N-1:0] bits,
  output logic met
);
  // Count set bits and compare with the coincidence figure
  always_comb begin
    int count;
    count = 0;
    for (int i = 0; i < N; i++) begin
      count = count + int'(bits[i]);
    end
    met = (count >= K);
  end
endmodule

/* verification/rtc_field_model.sv */
// Field model of flux channel bistables, permissive bistables and operator switches
`timescale 1ns/1ps
module rtc_field_model (
  output logic [3:0] pr_high_bist,
  output logic [3:0] pr_low_bist,
  output logic [3:0] pr_rate_bist,
  output logic [3:0] pr_p10_bist,
  output logic [1:0] ir_high_bist,
  output logic [1:0] ir_p6_bist,
  output logic [1:0] sr_high_bist,
  output logic manual_trip_sw,
  output logic [1:0] sr_reinstate_sw
);
  // Quiet plant at power-up: nothing tripped, switches released
  initial begin
    {pr_high_bist, pr_low_bist, pr_rate_bist, pr_p10_bist} = 16'h0000;
    {ir_high_bist, ir_p6_bist, sr_high_bist} = 6'h00;
    {manual_trip_sw, sr_reinstate_sw} = 3'h0;
  end

  // Levels change right after a clock edge and stay until the next command
  task automatic set_plant(input logic [15:0] pr, input logic [5:0] nr, input logic [2:0] sw);
    {pr_high_bist, pr_low_bist, pr_rate_bist, pr_p10_bist} <= pr;
    {ir_high_bist, ir_p6_bist, sr_high_bist} <= nr;
    {manual_trip_sw, sr_reinstate_sw} <= sw;
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the reactor trip coincidence logic
`timescale 1ns/1ps
module testbench;
  logic sys_clk, resetn, ce, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable, tb;
  logic [31:0] avs_writedata, avs_readdata, rd, ot_delta_t, ot_flux_diff, pzr_press;
  logic [3:0] pr_high_bist, pr_low_bist, pr_rate_bist, pr_p10_bist;
  logic [1:0] ir_high_bist, ir_p6_bist, sr_high_bist, sr_reinstate_sw, sr_byp;
  logic manual_trip_sw, ta, tbk, turbine_trip, ir_ann, sr_ann, lo_byp, ir_blk;
  logic [31:0] pa, pb;
  int seed = 49681;
  int fails = 0;
  int checks_done = 0;

  rtc_field_model u_field (.pr_high_bist(pr_high_bist), .pr_low_bist(pr_low_bist),
    .pr_rate_bist(pr_rate_bist), .pr_p10_bist(pr_p10_bist), .ir_high_bist(ir_high_bist),
    .ir_p6_bist(ir_p6_bist), .sr_high_bist(sr_high_bist), .manual_trip_sw(manual_trip_sw),
    .sr_reinstate_sw(sr_reinstate_sw));

  rtc_trip_logic dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pr_high_bist(pr_high_bist), .pr_low_bist(pr_low_bist),
    .pr_rate_bist(pr_rate_bist), .pr_p10_bist(pr_p10_bist), .ir_high_bist(ir_high_bist),
    .ir_p6_bist(ir_p6_bist), .sr_high_bist(sr_high_bist), .manual_trip_sw(manual_trip_sw),
    .sr_reinstate_sw(sr_reinstate_sw), .ot_delta_t(ot_delta_t), .ot_flux_diff(ot_flux_diff),
    .pzr_press(pzr_press), .train_a_trip_breaker(ta), .train_b_trip_breaker(tbk),
    .turbine_trip(turbine_trip), .ir_test_annunc(ir_ann), .sr_test_annunc(sr_ann));

  // Verdict and the end of the run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer held until waitrequest is seen low
  // Only the watchdog ends a wait that never sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic two_of(input logic [3:0] v);
    return $countones(v) >= 2;
  endfunction

  // Two of four loops above their own flux-adjusted setpoint
  function automatic logic ot_trip(input logic [31:0] dt, input logic [31:0] dif,
                                   input logic [31:0] pr);
    int n;
    int sp;
    int d;
    n = 0;
    for (int l = 0; l < 4; l++) begin
      d = $signed(dif[8*l+:8]);
      if (d < 0) d = -d;
      sp = int'(pr[8*l+:8]) - int'(rtc_pkg::OT_PRESS_NOM);
      sp = int'(rtc_pkg::OT_BASE) + (sp >>> rtc_pkg::OT_PRESS_SHIFT);
      if (d > int'(rtc_pkg::OT_DEADBAND)) sp = sp - (d - int'(rtc_pkg::OT_DEADBAND));
      if (int'(dt[8*l+:8]) > sp) n++;
    end
    return n >= 2;
  endfunction

  function automatic logic exp_trip(input int t);
    return two_of(pr_high_bist) || (two_of(pr_low_bist) && !lo_byp) || two_of(pr_rate_bist)
      || ((|(ir_high_bist & ~tb[1:0])) && !ir_blk) || ((|(sr_high_bist & ~tb[3:2])) && !sr_byp[t])
      || manual_trip_sw || ot_trip(ot_delta_t, ot_flux_diff, pzr_press);
  endfunction

  // Reference view of the automatic and manual reinstatements
  task automatic auto_clear();
    if ($countones(pr_p10_bist) <= 1) begin
      lo_byp = 1'b0;
      ir_blk = 1'b0;
    end
    if (ir_p6_bist == 2'b00) sr_byp = 2'b00;
    for (int t = 0; t < 2; t++) begin
      if (sr_reinstate_sw[t] && !two_of(pr_p10_bist)) sr_byp[t] = 1'b0;
    end
  endtask

  // Apply plant levels, make an operator request, then compare everything
  task automatic step(input logic [15:0] pr, input logic [5:0] nr, input logic [2:0] sw,
                      input logic [2:0] r);
    u_field.set_plant(pr, nr, sw);
    repeat (8) @(posedge sys_clk);
    auto_clear();
    bus(1'b1, rtc_pkg::REG_CTRL, 32'(r));
    if (r[rtc_pkg::CTRL_PR_LOW_BYP] && two_of(pr_p10_bist)) lo_byp = 1'b1;
    if (r[rtc_pkg::CTRL_IR_BLOCK] && two_of(pr_p10_bist)) ir_blk = 1'b1;
    if (r[rtc_pkg::CTRL_SR_BYP] && (|ir_p6_bist)) sr_byp = 2'b11;
    auto_clear();
    repeat (8) @(posedge sys_clk);
    chk(ta, exp_trip(0));
    chk(tbk, exp_trip(1));
    chk(turbine_trip, exp_trip(0) | exp_trip(1));
    chk(ir_ann, |tb[1:0]);
    chk(sr_ann, |tb[3:2]);
    bus(1'b0, rtc_pkg::REG_STATUS, 32'h0);
    chk(rd[9:8], {|ir_p6_bist, two_of(pr_p10_bist)});
    chk(rd[7:2], {sr_byp, ir_blk, ir_blk, lo_byp, lo_byp});
    chk(rd[1:0], {exp_trip(1), exp_trip(0)});
    chk(rd[16:10], {manual_trip_sw, ot_trip(ot_delta_t, ot_flux_diff, pzr_press),
        two_of(pr_rate_bist), |(sr_high_bist & ~tb[3:2]), |(ir_high_bist & ~tb[1:0]),
        two_of(pr_low_bist), two_of(pr_high_bist)});
  endtask

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end

  // Main sequence: register map, hand-written corners, then random plant states
  initial begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {ot_delta_t, ot_flux_diff, pzr_press} = {32'h0, 32'h0, 32'h80808080};
    {ce, avs_byteenable, tb, lo_byp, ir_blk, sr_byp} = {1'b1, 4'hF, 4'h0, 4'h0};
    repeat (16) @(posedge sys_clk);
    chk({avs_waitrequest, ta, tbk, turbine_trip}, 32'h8);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, rtc_pkg::REG_TEST_BYP, 32'h0);
    chk(rd, 32'(rtc_pkg::TEST_BYP_RESET));
    bus(1'b0, rtc_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'hC, 32'hF);
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, rtc_pkg::REG_TEST_BYP, 32'hF);
    avs_byteenable <= 4'hF;
    bus(1'b1, rtc_pkg::REG_STATUS, 32'hFFFF);
    bus(1'b0, rtc_pkg::REG_TEST_BYP, 32'h0);
    chk(rd, 32'h0);
    // Clock enable low freezes the pin chain, so a manual trip waits for it
    ce <= 1'b0;
    u_field.set_plant(16'h0000, 6'h00, 3'h4);
    repeat (8) @(posedge sys_clk);
    chk(ta, 1'b0);
    ce <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(ta, 1'b1);
    step(16'h1000, 6'h00, 3'h0, 3'h7);
    step(16'h0301, 6'h00, 3'h0, 3'h1);
    step(16'h0303, 6'h00, 3'h0, 3'h1);
    step(16'h5303, 6'h00, 3'h0, 3'h7);
    step(16'h030A, 6'h00, 3'h0, 3'h0);
    step(16'h000F, 6'h10, 3'h0, 3'h2);
    step(16'h0008, 6'h10, 3'h0, 3'h0);
    step(16'h0000, 6'h06, 3'h0, 3'h4);
    step(16'h0000, 6'h06, 3'h2, 3'h0);
    step(16'h0000, 6'h02, 3'h0, 3'h0);
    step(16'h0000, 6'h00, 3'h4, 3'h0);
    tb = 4'h5;
    bus(1'b1, rtc_pkg::REG_TEST_BYP, 32'h5);
    step(16'h0000, 6'h11, 3'h0, 3'h0);
    tb = 4'h0;
    bus(1'b1, rtc_pkg::REG_TEST_BYP, 32'h0);
    ot_delta_t <= 32'h00009898;
    ot_flux_diff <= 32'h00002020;
    step(16'h0000, 6'h00, 3'h0, 3'h0);
    ot_flux_diff <= 32'h00001010;
    step(16'h0000, 6'h00, 3'h0, 3'h0);
    ot_flux_diff <= 32'h00000020;
    step(16'h0000, 6'h00, 3'h0, 3'h0);
    for (int i = 0; i < 80; i++) begin
      if (i % 8 == 0) begin
        tb = 4'($random(seed));
        bus(1'b1, rtc_pkg::REG_TEST_BYP, 32'(tb));
      end
      for (int l = 0; l < 4; l++) begin
        ot_delta_t[8*l+:8] <= 8'h30 + 8'($random(seed) & 127);
        pzr_press[8*l+:8] <= 8'h60 + 8'($random(seed) & 63);
        ot_flux_diff[8*l+:8] <= 8'($random(seed) & 127) - 8'h40;
      end
      pa = $random(seed);
      pb = $random(seed);
      step({pa[3:0] & pb[3:0], pa[7:4] & pb[7:4], pa[11:8] & pb[11:8], pa[15:12]},
           {pa[17:16] & pb[17:16], pa[19:18], pa[21:20] & pb[21:20]},
           {pa[24:22] == 3'h0, pa[26:25]}, pb[30:28]);
    end
    end_of_test();
  end
endmodule
